// file: hw/adc_pwm_common.sv
/*
 * constants shared by the converter controller and its pwm timer,
 * plus the pwm timer itself.
 * assumes one subsystem clock at 100 MHz and a synchronous active-high reset.
 */
`timescale 1ns/1ps

// Operation
// - external voltage feeds comparator plus input, dac level feeds minus input.
// - dac level code is 6 bits, 64 reference levels.
// - each measurement starts with the code at mid-scale, 32 of 64.
// - comparator says input above level: increment code, compare again.
// - comparator says input below level: decrement code, compare again.
// - fixed iteration count per measurement, so trigger-to-pwm latency is constant.
// - an edge on debounced button while idle starts a measurement, then updates pwm.
// - pwm period is converged code times 128 clock cycles.
// - pwm duty is exactly half of the period for every code.
// - period compare and duty compare are both loaded from the result.
// - pwm timer runs from the subsystem clock.
package adc_pwm_pkg;
    localparam int          CODE_W        = 6;
    localparam logic [5:0]  CODE_MID      = 6'h20;
    localparam logic [5:0]  CODE_MAX      = 6'h3F;
    localparam logic [5:0]  CODE_MIN      = 6'h00;
    localparam int          PERIOD_SHIFT  = 7;       // 128 clock cycles per code step
    localparam int          DUTY_SHIFT    = 6;       // half of the period
    localparam int          CNT_W         = 13;      // 63 * 128 = 8064 fits
    localparam logic [6:0]  ITER_COUNT    = 7'h20;   // 32 steps reach either rail
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          SETTLE_NS     = 100;     // comparator settle per step
    localparam logic [7:0]  SETTLE_CYC    =
        8'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          LATENCY_CYC   = 1 + 32 * (10 + 1);

    function automatic logic [CNT_W-1:0] period_of(input logic [5:0] code);
        period_of = {code, 7'h00};
    endfunction

    function automatic logic [CNT_W-1:0] duty_of(input logic [5:0] code);
        duty_of = {1'b0, code, 6'h00};
    endfunction
endpackage

module pwm_timer
    import adc_pwm_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // compare values from the controller
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] period_in,
    input  wire logic [CNT_W-1:0] duty_in,
    // output
    output logic                  pwm_out
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] pwm_period_compare;
        logic [CNT_W-1:0] pwm_duty_compare;
        logic             out;
    } tmr_t;

    tmr_t s;
    tmr_t next_s;

    // up counter against period compare, high below duty compare
    always_comb begin
        next_s = s;
        if (load) begin
            next_s.pwm_period_compare = period_in;
            next_s.pwm_duty_compare   = duty_in;
            next_s.cnt                = '0;
        end else if (s.pwm_period_compare == '0 ||
                     s.cnt == s.pwm_period_compare - 13'h0001) begin
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + 13'h0001;
        end
        // a zero period holds the pin low rather than glitching
        next_s.out = (next_s.pwm_period_compare != '0) &&
                     (next_s.cnt < next_s.pwm_duty_compare);
    end

    // runs straight from the subsystem clock, no prescaler
    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pwm_out = s.out;

    a_zero_low: assert property (@(posedge clk) disable iff (srst)
        s.pwm_period_compare == '0 |-> !s.out)
        else $error("pwm active with zero period");
    a_wrap_point: assert property (@(posedge clk) disable iff (srst)
        !load && s.pwm_period_compare != '0 && s.cnt == s.pwm_period_compare - 13'h0001
        |=> s.cnt == '0)
        else $error("counter did not wrap at period compare");
    c_pwm_rise: cover property (@(posedge clk) disable iff (srst) $rose(s.out));
endmodule

// file: hw/adc_pwm_ctrl.sv
/*
 * comparator-based 6-bit converter that sets a 50% pwm period.
 * assumes the button pin and comparator output are asynchronous, the
 * pin is debounced externally, and clk is the subsystem clock.
 */
`timescale 1ns/1ps

module adc_pwm_ctrl
    import adc_pwm_pkg::*;
#(
    parameter logic [6:0] ITERATIONS = ITER_COUNT,
    parameter logic [7:0] SETTLE     = SETTLE_CYC
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // pins and analog front end
    input  wire logic              button_input_pin,
    input  wire logic              comparator_out,
    output logic [CODE_W-1:0]      dac_level_code,
    output logic                   comparator_plus_ext,
    output logic                   comparator_minus_dac,
    // result
    output logic                   pwm_output_pin,
    output logic                   busy
);
    typedef enum logic [1:0] {IDLE, SETTLING, DECIDE, DONE} state_t;

    typedef struct packed {
        state_t           st;
        logic [5:0]       code;
        logic [6:0]       iter;
        logic [7:0]       settle;
        logic [2:0]       btn_sync;
        logic [1:0]       btn_fill;
        logic [2:0]       cmp_sync;
        logic             btn_level;
        logic             btn_armed;
        logic             btn_edge;
        logic             cmp_level;
        logic             busy;
        logic             load;
        logic             route;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] duty;
    } ctrl_t;

    ctrl_t s;
    ctrl_t next_s;
    logic  pwm_q;

    always_comb begin
        next_s          = s;
        next_s.load     = 1'b0;
        next_s.btn_edge = 1'b0;
        next_s.route    = 1'b1;
        // three-stage synchronisers; only stages 2 and 3 are compared
        next_s.btn_sync = {s.btn_sync[1:0], button_input_pin};
        next_s.cmp_sync = {s.cmp_sync[1:0], comparator_out};
        if (s.cmp_sync[1] == s.cmp_sync[2]) begin
            next_s.cmp_level = s.cmp_sync[2];
        end
        // stages 2 and 3 hold real pin samples only three edges after reset;
        // comparing them earlier would arm on reset zeros and fake an edge
        if (s.btn_fill != 2'h3) begin
            next_s.btn_fill = s.btn_fill + 2'h1;
        end
        // first agreement after reset only arms, so an idle-high pin is no edge
        if (s.btn_fill == 2'h3 && s.btn_sync[1] == s.btn_sync[2]) begin
            next_s.btn_level = s.btn_sync[2];
            next_s.btn_armed = 1'b1;
            next_s.btn_edge  = s.btn_armed && (s.btn_level != s.btn_sync[2]);
        end
        unique case (s.st)
            IDLE: begin
                // edges during a measurement are dropped, not queued
                if (s.btn_edge) begin
                    next_s.st     = SETTLING;
                    next_s.code   = CODE_MID;
                    next_s.iter   = '0;
                    next_s.settle = '0;
                    next_s.busy   = 1'b1;
                end
            end
            SETTLING: begin
                // wait covers dac settling plus synchroniser delay
                if (s.settle == SETTLE - 8'h01) begin
                    next_s.st = DECIDE;
                end else begin
                    next_s.settle = s.settle + 8'h01;
                end
            end
            DECIDE: begin
                if (s.cmp_level) begin
                    if (s.code != CODE_MAX) begin
                        next_s.code = s.code + 6'h01;
                    end
                end else if (s.code != CODE_MIN) begin
                    next_s.code = s.code - 6'h01;
                end
                next_s.settle = '0;
                next_s.iter   = s.iter + 7'h01;
                // fixed count, no early exit, keeps latency constant
                if (s.iter == ITERATIONS - 7'h01) begin
                    next_s.st     = DONE;
                    next_s.load   = 1'b1;
                    next_s.period = period_of(next_s.code);
                    next_s.duty   = duty_of(next_s.code);
                end else begin
                    next_s.st = SETTLING;
                end
            end
            DONE: begin
                next_s.st   = IDLE;
                next_s.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '{st: IDLE, code: CODE_MID, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // timer keeps the previous waveform until the next load
    pwm_timer u_timer (
        .clk       (clk),
        .srst      (srst),
        .load      (s.load),
        .period_in (s.period),
        .duty_in   (s.duty),
        .pwm_out   (pwm_q)
    );

    // outputs straight from flops
    assign dac_level_code       = s.code;
    assign comparator_plus_ext  = s.route;
    assign comparator_minus_dac = s.route;
    assign pwm_output_pin       = pwm_q;
    assign busy                 = s.busy;

    // helper: cycles since the measurement was accepted
    logic [9:0] lat_cnt;
    always_ff @(posedge clk) begin
        if (srst) begin
            lat_cnt <= '0;
        end else if (s.st == IDLE && s.btn_edge) begin
            lat_cnt <= 10'h001;
        end else if (s.busy) begin
            lat_cnt <= lat_cnt + 10'h001;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    // start and stepping
    a_mid_start: assert property (
        s.st == IDLE && s.btn_edge |=> s.code == CODE_MID && s.busy)
        else $error("measurement did not start at mid-scale");
    a_start_clear: assert property (
        s.st == IDLE && s.btn_edge |=> s.iter == 7'h00 && s.settle == 8'h00)
        else $error("iteration or settle count not cleared at start");
    a_step_up: assert property (
        s.st == DECIDE && s.cmp_level && s.code != CODE_MAX
        |=> s.code == $past(s.code) + 6'h01)
        else $error("code not incremented on high compare");
    a_step_down: assert property (
        s.st == DECIDE && !s.cmp_level && s.code != CODE_MIN
        |=> s.code == $past(s.code) - 6'h01)
        else $error("code not decremented on low compare");
    a_rail_hold: assert property (
        s.st == DECIDE &&
        ((s.cmp_level && s.code == CODE_MAX) || (!s.cmp_level && s.code == CODE_MIN))
        |=> $stable(s.code))
        else $error("code left its rail");

    // fixed-length measurement
    a_settle_count: assert property (
        s.st == SETTLING && s.settle != SETTLE - 8'h01
        |=> s.st == SETTLING && s.settle == $past(s.settle) + 8'h01)
        else $error("settle wait cut short");
    a_decide_once: assert property (
        s.st == DECIDE |=> s.st != DECIDE)
        else $error("decision step repeated");
    a_iter_range: assert property (
        s.iter <= ITERATIONS)
        else $error("iteration count overran");
    a_fixed_latency: assert property (
        s.load |-> lat_cnt == 10'(LATENCY_CYC))
        else $error("measurement latency not constant");

    // result hand-over to the timer
    a_period_code: assert property (
        s.load |-> s.period == {s.code, 7'h00})
        else $error("period compare does not match code");
    a_half_duty: assert property (
        s.load |-> {s.duty, 1'b0} == {1'b0, s.period})
        else $error("duty compare not half the period");
    a_load_once: assert property (
        s.load |=> !s.load && s.st == IDLE && !s.busy)
        else $error("result load not a single pulse");
    a_hold_pwm: assert property (
        !s.load |-> $stable(s.period) && $stable(s.duty))
        else $error("compares changed without a result");
    a_idle_quiet: assert property (
        s.st == IDLE |-> !s.busy && !s.load)
        else $error("busy or load while idle");

    // trigger and routing
    a_edge_armed: assert property (
        s.btn_edge |-> $past(s.btn_armed))
        else $error("button edge before the pin was armed");
    a_busy_ignore: assert property (
        s.busy && s.st != DONE |=> s.busy)
        else $error("measurement aborted");
    a_route_fixed: assert property (
        !$past(srst) |-> comparator_plus_ext && comparator_minus_dac)
        else $error("comparator inputs not routed");

    c_done: cover property (s.load);
    c_top: cover property (s.load && s.code == CODE_MAX);
    c_bottom: cover property (s.load && s.code == CODE_MIN);
    c_edge_busy: cover property (s.busy && s.btn_edge);
endmodule

// file: tb/cmp_model.sv
/*
 * comparator front end: external level against the reference level code.
 * assumes vin is given in reference steps and that clk is the subsystem clock.
 */
`timescale 1ns/1ps

module cmp_model
    import adc_pwm_pkg::*;
(
    // clock
    input  wire logic              clk,
    // analog side, input level in reference steps
    input  wire logic [6:0]        vin,
    input  wire logic [CODE_W-1:0] dac_level_code,
    input  wire logic              comparator_plus_ext,
    input  wire logic              comparator_minus_dac,
    // result
    output logic                   comparator_out
);
    logic junk = 1'b0;

    // unrouted inputs give a changing level, so a wrong route never looks right
    always @(posedge clk) begin
        junk <= ~junk;
    end

    // high while the input is above the reference level
    assign comparator_out = (comparator_plus_ext && comparator_minus_dac) ?
                            (vin > {1'b0, dac_level_code}) : junk;
endmodule

// file: tb/tb.sv
/*
 * self-checking bench for the comparator-to-pwm controller.
 * assumes default iteration and settle counts, ten time units per clk cycle.
 */
`timescale 1ns/1ps

module tb;
    import adc_pwm_pkg::*;
    typedef struct {logic [6:0] vin; logic [5:0] code;} row_t;

    logic              clk  = 1'b0;
    logic              srst = 1'b1;
    logic              button = 1'b0;
    logic [6:0]        vin  = 7'h00;
    logic              cmp;
    logic [CODE_W-1:0] code;
    logic              r_plus;
    logic              r_minus;
    logic              pwm;
    logic              busy;
    int                n_fail  = 0;
    int                n_tests = 0;
    int                n;
    // tracking ends at the level, dithering below it after an odd leftover
    row_t rows[5] = '{'{7'h28, 6'h28}, '{7'h0A, 6'h0A}, '{7'h64, 6'h3F},
                      '{7'h00, 6'h00}, '{7'h21, 6'h20}};

    always #5 clk = ~clk;

    adc_pwm_ctrl i_adc_pwm_ctrl (.clk(clk), .srst(srst), .button_input_pin(button),
        .comparator_out(cmp), .dac_level_code(code), .comparator_plus_ext(r_plus),
        .comparator_minus_dac(r_minus), .pwm_output_pin(pwm), .busy(busy));
    cmp_model i_cmp_model (.clk(clk), .vin(vin), .dac_level_code(code),
        .comparator_plus_ext(r_plus), .comparator_minus_dac(r_minus), .comparator_out(cmp));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // bounded wait for busy (sel 0) or pwm (sel 1) to reach lvl; n counts cycles
    task automatic wait_sig(input bit sel, input logic lvl, input int bound, output int k);
        k = 0;
        while (((sel ? pwm : busy) !== lvl) && k < bound) begin
            @(negedge clk);
            k++;
        end
        if (k >= bound) begin
            n_fail++;
            $display("wrong value wait sel %0d expected %0h seen %0h", sel, lvl,
                     (sel ? pwm : busy));
            close_out();
        end
    endtask

    // one half period of pwm high and low, or a quiet pin for code 0
    task automatic pwm_check(input logic [5:0] c);
        int bad;
        bad = 0;
        if (c == 6'h00) begin
            repeat (300) begin
                @(negedge clk);
                if (pwm !== 1'b0) bad++;
            end
            check("pwm idle", bad, 0);
        end else begin
            wait_sig(1, 1'b0, 9000, n);
            wait_sig(1, 1'b1, 9000, n);
            wait_sig(1, 1'b0, 9000, n);
            check("pwm high", n, 32'(c) * 64);
            wait_sig(1, 1'b1, 9000, n);
            check("pwm low", n, 32'(c) * 64);
        end
    endtask

    task automatic measure(input logic [6:0] v, input logic [5:0] c);
        vin = v;
        @(negedge clk);
        button = ~button;
        wait_sig(0, 1'b1, 20, n);
        check("start code", code, CODE_MID);
        check("routes", {r_plus, r_minus}, 2'b11);
        wait_sig(0, 1'b0, 400, n);
        check("busy cycles", n, LATENCY_CYC);
        check("result code", code, c);
        pwm_check(c);
    endtask

    initial begin
        repeat (12) @(negedge clk);
        check("reset state", {busy, pwm, code}, {2'b00, CODE_MID});
        srst = 1'b0;
        repeat (6) @(negedge clk);
        foreach (rows[i]) begin
            measure(rows[i].vin, rows[i].code);
        end
        // a second edge during a measurement is dropped
        measure(7'h64, 6'h3F);
        vin = 7'h0A;
        button = ~button;
        wait_sig(0, 1'b1, 20, n);
        repeat (50) @(negedge clk);
        button = ~button;
        wait_sig(0, 1'b0, 400, n);
        repeat (30) @(negedge clk);
        check("edge while busy", busy, 1'b0);
        check("busy result", code, 6'h0A);
        // input moves without a trigger: pwm keeps the result of the last run
        vin = 7'h10;
        pwm_check(6'h0A);
        check("held code", code, 6'h0A);
        // reset in mid-measurement, released with the pin idling high
        button = ~button;
        wait_sig(0, 1'b1, 20, n);
        repeat (20) @(negedge clk);
        srst = 1'b1;
        repeat (3) @(negedge clk);
        check("mid reset", {busy, pwm, code}, {2'b00, CODE_MID});
        check("reset routes", {r_plus, r_minus}, 2'b00);
        srst = 1'b0;
        repeat (12) @(negedge clk);
        check("no false edge", busy, 1'b0);
        measure(7'h0A, 6'h0A);
        close_out();
    end
endmodule
